// ---- design/pll_pkg.sv ----
// shared constants of the loop control block: map, fields, reset values
package pll_pkg;

	// ------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_INDEX = 8'h1c; // loop_control
	localparam logic [7:0] BWC_INDEX  = 8'h1d; // loop_bandwidth_control
	localparam logic [7:0] PROG_INDEX = 8'h1e; // loop_multiplier_program
	localparam int unsigned ADDR_LSB  = 2;     // word aligned
	localparam int unsigned INDEX_W   = 8;

	// ------------------------------------------------------------
	// loop_control fields
	// ------------------------------------------------------------
	localparam int unsigned CTRL_IE_BIT   = 7;
	localparam int unsigned CTRL_FLAG_BIT = 6;
	localparam int unsigned CTRL_ON_BIT   = 5;
	localparam int unsigned CTRL_BCS_BIT  = 4;
	localparam logic [3:0]  CTRL_LOW_ONES = 4'hf; // no function, read 1s

	// ------------------------------------------------------------
	// loop_bandwidth_control fields
	// ------------------------------------------------------------
	localparam int unsigned BWC_AUTO_BIT = 7;
	localparam int unsigned BWC_LOCK_BIT = 6;
	localparam int unsigned BWC_ACQ_BIT  = 5;
	localparam int unsigned BWC_XLD_BIT  = 4;

	// ------------------------------------------------------------
	// loop_multiplier_program fields and reset values
	// ------------------------------------------------------------
	localparam int unsigned PROG_MUL_LSB = 4;
	localparam int unsigned PROG_VRS_LSB = 0;
	localparam logic [3:0]  MUL_RESET    = 4'h6;
	localparam logic [3:0]  VRS_RESET    = 4'h6;
	localparam logic        ON_RESET     = 1'b1;

	// ------------------------------------------------------------
	// clock switch timing
	// ------------------------------------------------------------
	localparam logic [1:0]  SWITCH_EDGES = 2'h3; // edges of each source

endpackage : pll_pkg

// ---- design/pin_sync.sv ----
// three-stage synchroniser whose output follows once stages two and three agree
`timescale 1ns/100ps
module pin_sync
	import pll_pkg::*;
#(
	parameter int unsigned WIDTH = 4
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	initial begin
		if (WIDTH < 1) $error("pin_sync: WIDTH must be at least 1");
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [WIDTH-1:0] s1;  // metastable stage, read by s2 only
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;   // filtered level
	} sync_s;

	sync_s sync_reg;
	sync_s sync_next;

	// per-bit agreement of stages two and three
	logic [WIDTH-1:0] agree;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_agree
			assign agree[g] = ~(sync_reg.s2[g] ^ sync_reg.s3[g]);
		end
	endgenerate

	// next state: shift, then update agreed bits
	always_comb begin
		sync_next    = sync_reg;
		sync_next.s1 = async_in;
		sync_next.s2 = sync_reg.s1;
		sync_next.s3 = sync_reg.s2;
		sync_next.q  = (sync_reg.s3 & agree) | (sync_reg.q & ~agree);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg.q;

endmodule : pin_sync

// ---- design/clock_switch.sv ----
// glitch-free base clock source switch with divide by two
`timescale 1ns/100ps
module clock_switch
	import pll_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic xtal_rise,   // one-cycle pulse per crystal edge
	input  wire logic vco_rise,    // one-cycle pulse per vco edge
	input  wire logic select_vco,  // requested source
	input  wire logic run,         // oscillator enable
	output logic      base_clock_out,
	output logic      switching
);

	typedef enum logic {SW_RUN, SW_WAIT} sw_state_e;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		sw_state_e  state;
		logic       cur_vco;  // source now in use
		logic [1:0] xcnt;     // crystal edges seen in wait
		logic [1:0] vcnt;     // vco edges seen in wait
		logic       out;      // divided clock
	} sw_s;

	sw_s sw_reg;
	sw_s sw_next;

	// next state: toggle on source edges, freeze output while switching
	always_comb begin
		sw_next = sw_reg;
		case (sw_reg.state)
			SW_RUN: begin
				if (select_vco != sw_reg.cur_vco) begin
					sw_next.state = SW_WAIT;
					sw_next.xcnt  = '0;
					sw_next.vcnt  = '0;
				end else if (sw_reg.cur_vco ? vco_rise : xtal_rise) begin
					sw_next.out = ~sw_reg.out;
				end
			end
			SW_WAIT: begin
				// output held static until both sources ticked
				if (xtal_rise && sw_reg.xcnt != SWITCH_EDGES) begin
					sw_next.xcnt = sw_reg.xcnt + 2'h1;
				end
				if (vco_rise && sw_reg.vcnt != SWITCH_EDGES) begin
					sw_next.vcnt = sw_reg.vcnt + 2'h1;
				end
				if (sw_reg.xcnt == SWITCH_EDGES &&
				    sw_reg.vcnt == SWITCH_EDGES) begin
					sw_next.cur_vco = select_vco;
					sw_next.state   = SW_RUN;
				end
			end
			default: begin
				sw_next.state = SW_RUN;
			end
		endcase
		// stop: output low, crystal selected, back to run
		if (!run) begin
			sw_next.state   = SW_RUN;
			sw_next.cur_vco = 1'b0;
			sw_next.out     = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_reg <= '{state: SW_RUN, default: '0};
		end else begin
			sw_reg <= sw_next;
		end
	end

	assign base_clock_out = sw_reg.out;
	assign switching      = (sw_reg.state == SW_WAIT);

endmodule : clock_switch

// ---- design/pll_control.sv ----
// register control, lock tracking and base clock select of the loop
//
// Operation
// - lock change sets flag; flag with enable interrupts
// - manual mode: enable ignores writes, reads 0
// - control register read clears lock flag
// - manual mode: flag reads 0, no interrupt
// - power-on bit enables loop, resets to 1
// - power-on cannot clear while vco selected
// - vco select ignored while loop off
// - select picks vco or crystal, halved
// - switch waits three edges each, output frozen
// - reset and stop clear source select
// - control low nibble reads all ones
// - bandwidth mode bit, 1 automatic, reset 0
// - lock indicator only in automatic mode
// - acquisition bit: status auto, control manual
// - manual acquisition value kept during automatic
// - crystal check: write 1, wait, read
// - crystal loss reads 0 on crystal source
// - multiplier field, zero acts as one, reset 6
// - program register frozen while loop on
// - range zero disables loop, blocks vco
// - stop holds crystal, base, interrupt low
`timescale 1ns/100ps
module pll_control
	import pll_pkg::*;
#(
	parameter int unsigned ADDR_W = 12
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              crystal_clock,
	input  wire logic              vco_clock,
	input  wire logic              loop_locked_in,
	input  wire logic              loop_tracking_in,
	input  wire logic              oscillator_enable_in,
	output logic                   crystal_clock_out,
	output logic                   base_clock_out,
	output logic                   loop_irq_request,
	output logic                   loop_enable_out,
	output logic                   auto_bandwidth_out,
	output logic                   manual_tracking_out,
	output logic      [3:0]        feedback_multiplier_out,
	output logic      [3:0]        vco_range_out,
	output logic      [3:0]        factory_test_out
);

	initial begin
		if (ADDR_W < INDEX_W + ADDR_LSB) begin
			$error("pll_control: ADDR_W too narrow for register map");
		end
	end

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic [3:0] pin_level;  // xtal, vco, locked, tracking
	logic       xtal_lvl;
	logic       vco_lvl;
	logic       locked_lvl;
	logic       track_lvl;

	pin_sync #(.WIDTH(4)) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({crystal_clock, vco_clock,
		            loop_locked_in, loop_tracking_in}),
		.sync_out (pin_level)
	);

	assign xtal_lvl   = pin_level[3];
	assign vco_lvl    = pin_level[2];
	assign locked_lvl = pin_level[1];
	assign track_lvl  = pin_level[0];

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic        ie;       // loop_irq_enable
		logic        flag;     // lock_change_flag
		logic        on;       // loop_power_on
		logic        base_clock_source_select;      // base_clock_source_select
		logic        auto_bw;  // automatic bandwidth mode
		logic        lock;     // lock indicator
		logic        acq_sw;   // manual tracking_not_acquire copy
		logic        crystal_loss_check;      // crystal_loss_check pending
		logic [3:0]  test;     // factory_test_bits
		logic [3:0]  mul;      // feedback_multiplier
		logic [3:0]  vrs;      // vco_range_multiplier
		logic        xtal_d;   // previous crystal level
		logic        vco_d;    // previous vco level
		logic        xtal_out; // gated crystal clock
		logic        irq;      // interrupt request
		logic [31:0] rdata;    // read data captured in setup
	} ctl_s;

	ctl_s ctl_reg;
	ctl_s ctl_next;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic [INDEX_W-1:0] index;
	logic               sel_ctrl;
	logic               sel_bwc;
	logic               sel_prog;
	logic               mapped;
	logic               access;   // access phase, always completes
	logic               wr_ctrl;
	logic               wr_bwc;
	logic               wr_prog;
	logic               rd_ctrl;
	logic               xtal_rise;
	logic               vco_rise;
	logic               acq_view; // acquisition bit as read
	logic               switching;

	assign index    = paddr[ADDR_LSB +: INDEX_W];
	assign sel_ctrl = (index == CTRL_INDEX);
	assign sel_bwc  = (index == BWC_INDEX);
	assign sel_prog = (index == PROG_INDEX);
	assign mapped   = sel_ctrl | sel_bwc | sel_prog;
	assign access   = psel & penable;
	assign wr_ctrl  = access & pwrite & sel_ctrl;
	assign wr_bwc   = access & pwrite & sel_bwc;
	assign wr_prog  = access & pwrite & sel_prog;
	assign rd_ctrl  = access & ~pwrite & sel_ctrl;

	// edge pulses from the filtered clock levels
	assign xtal_rise = xtal_lvl & ~ctl_reg.xtal_d;
	assign vco_rise  = vco_lvl & ~ctl_reg.vco_d;

	// automatic mode shows the loop, manual shows the stored choice
	assign acq_view = ctl_reg.auto_bw ? track_lvl : ctl_reg.acq_sw;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		ctl_next        = ctl_reg;
		ctl_next.xtal_d = xtal_lvl;
		ctl_next.vco_d  = vco_lvl;

		// lock indicator is meaningless in manual mode
		ctl_next.lock = ctl_reg.auto_bw & locked_lvl;

		// any read of the control register clears the flag
		if (rd_ctrl) begin
			ctl_next.flag = 1'b0;
		end
		// a lock toggle in the same cycle still wins
		if (ctl_next.lock != ctl_reg.lock) begin
			ctl_next.flag = 1'b1;
		end

		// crystal edge proves the reference alive
		if (xtal_rise) begin
			ctl_next.crystal_loss_check = 1'b0;
		end

		// control register write
		if (wr_ctrl) begin
			if (ctl_reg.auto_bw) begin
				ctl_next.ie = pwdata[CTRL_IE_BIT];
			end
			// cannot drop power while vco drives the base clock
			ctl_next.on = pwdata[CTRL_ON_BIT] | ctl_reg.base_clock_source_select;
			// old and new power state: no select while turning off
			ctl_next.base_clock_source_select = pwdata[CTRL_BCS_BIT] & ctl_reg.on & ctl_next.on &
			               (ctl_reg.vrs != 4'h0);
		end

		// bandwidth register write
		if (wr_bwc) begin
			ctl_next.auto_bw = pwdata[BWC_AUTO_BIT];
			if (!ctl_reg.auto_bw) begin
				ctl_next.acq_sw = pwdata[BWC_ACQ_BIT];
			end
			if (pwdata[BWC_XLD_BIT]) begin
				ctl_next.crystal_loss_check = 1'b1;
			end
			ctl_next.test = pwdata[3:0];
		end

		// program register only while the loop is off
		if (wr_prog && !ctl_reg.on) begin
			ctl_next.mul = pwdata[PROG_MUL_LSB +: 4];
			ctl_next.vrs = pwdata[PROG_VRS_LSB +: 4];
		end

		// range zero forces the crystal source
		if (ctl_next.vrs == 4'h0) begin
			ctl_next.base_clock_source_select = 1'b0;
		end
		// stop forces the crystal source
		if (!oscillator_enable_in) begin
			ctl_next.base_clock_source_select = 1'b0;
		end
		// manual mode: enable and flag held clear
		if (!ctl_next.auto_bw) begin
			ctl_next.ie   = 1'b0;
			ctl_next.flag = 1'b0;
		end

		// outputs held low in stop
		ctl_next.xtal_out = xtal_lvl & oscillator_enable_in;
		ctl_next.irq = ctl_next.flag & ctl_next.ie &
		               oscillator_enable_in;

		// read data captured in the setup cycle
		if (psel && !penable) begin
			ctl_next.rdata = 32'h0;
			if (sel_ctrl) begin
				ctl_next.rdata[7:0] = {ctl_reg.ie, ctl_reg.flag,
				                       ctl_reg.on, ctl_reg.base_clock_source_select,
				                       CTRL_LOW_ONES};
			end else if (sel_bwc) begin
				ctl_next.rdata[7:0] = {ctl_reg.auto_bw, ctl_reg.lock,
				                       acq_view,
				                       ctl_reg.crystal_loss_check & ctl_reg.base_clock_source_select,
				                       ctl_reg.test};
			end else if (sel_prog) begin
				ctl_next.rdata[7:0] = {ctl_reg.mul, ctl_reg.vrs};
			end
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_reg <= '{on: ON_RESET, mul: MUL_RESET, vrs: VRS_RESET,
			             default: '0};
		end else begin
			ctl_reg <= ctl_next;
		end
	end

	// ------------------------------------------------------------
	// base clock
	// ------------------------------------------------------------
	clock_switch u_switch (
		.pclk           (pclk),
		.presetn        (presetn),
		.xtal_rise      (xtal_rise),
		.vco_rise       (vco_rise),
		.select_vco     (ctl_reg.base_clock_source_select),
		.run            (oscillator_enable_in),
		.base_clock_out (base_clock_out),
		.switching      (switching)
	);

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign prdata  = ctl_reg.rdata;
	assign pready  = 1'b1;                // no wait states
	assign pslverr = access & ~mapped;    // unmapped address
	assign crystal_clock_out   = ctl_reg.xtal_out;
	assign loop_irq_request    = ctl_reg.irq;
	assign loop_enable_out     = ctl_reg.on & (ctl_reg.vrs != 4'h0) &
	                             oscillator_enable_in;
	assign auto_bandwidth_out  = ctl_reg.auto_bw;
	assign manual_tracking_out = ctl_reg.acq_sw;
	assign feedback_multiplier_out = (ctl_reg.mul == 4'h0) ? 4'h1 :
	                                 ctl_reg.mul;
	assign vco_range_out    = ctl_reg.vrs;
	assign factory_test_out = ctl_reg.test;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence seq_lock_toggle;
		ctl_reg.auto_bw && locked_lvl ##1 ctl_reg.auto_bw && locked_lvl;
	endsequence

	sequence seq_ctrl_read;
		psel && !penable && sel_ctrl && !pwrite ##1 rd_ctrl;
	endsequence

	AST_LOCK_SETS_FLAG: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(ctl_reg.lock) && ctl_reg.auto_bw |-> ctl_reg.flag)
		else $error("lock change did not set flag");

	AST_MANUAL_NO_IRQ: assert property (
		@(posedge pclk) disable iff (!presetn)
		!ctl_reg.auto_bw |-> !ctl_reg.flag && !loop_irq_request)
		else $error("flag or irq in manual mode");

	AST_MANUAL_IE_ZERO: assert property (
		@(posedge pclk) disable iff (!presetn)
		!ctl_reg.auto_bw |-> !ctl_reg.ie)
		else $error("enable set in manual mode");

	AST_READ_CLEARS_FLAG: assert property (
		@(posedge pclk) disable iff (!presetn)
		seq_ctrl_read ##0 (ctl_next.lock == ctl_reg.lock) |=> !ctl_reg.flag)
		else $error("control read kept flag");

	AST_RESERVED_ONES: assert property (
		@(posedge pclk) disable iff (!presetn)
		seq_ctrl_read |-> prdata[3:0] == 4'hf)
		else $error("reserved bits not ones");

	AST_BCS_HOLDS_ON: assert property (
		@(posedge pclk) disable iff (!presetn)
		ctl_reg.base_clock_source_select |-> ctl_reg.on)
		else $error("loop off with vco selected");

	AST_BCS_NEEDS_ON: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(ctl_reg.base_clock_source_select) |-> $past(ctl_reg.on) && ctl_reg.vrs != 4'h0)
		else $error("vco selected with loop off");

	AST_STOP_QUIET: assert property (
		@(posedge pclk) disable iff (!presetn)
		!oscillator_enable_in [*2] |-> !base_clock_out &&
		!crystal_clock_out && !loop_irq_request && !ctl_reg.base_clock_source_select)
		else $error("outputs active in stop");

	AST_PROG_FROZEN: assert property (
		@(posedge pclk) disable iff (!presetn)
		ctl_reg.on |=> $stable({ctl_reg.mul, ctl_reg.vrs}))
		else $error("program register changed while on");

	AST_XLD_ZERO: assert property (
		@(posedge pclk) disable iff (!presetn)
		psel && !penable && sel_bwc && !ctl_reg.base_clock_source_select |=> !prdata[4])
		else $error("crystal loss read 1 on crystal source");

	AST_SWITCH_FROZEN: assert property (
		@(posedge pclk) disable iff (!presetn)
		switching && oscillator_enable_in |=> $stable(base_clock_out))
		else $error("base clock moved during switch");

endmodule : pll_control

// ---- testbench/pll_partner.sv ----
// far-side model: crystal and vco sources, analog lock and tracking status
`timescale 1ns/100ps
module pll_partner #(
	parameter int XH = 170, // crystal half period, ns
	parameter int VH = 130  // vco half period, ns
) (
	input  wire logic xtal_run,         // crystal oscillating
	input  wire logic lock_req,         // lock state the loop reports
	input  wire logic trk_req,          // tracking state the loop reports
	output logic      crystal_clock,
	output logic      vco_clock,
	output logic      loop_locked_in,
	output logic      loop_tracking_in
);
	// ------------------------------------------------------------
	// sources, unrelated in phase to pclk
	// ------------------------------------------------------------
	initial crystal_clock = 1'b0;
	initial vco_clock = 1'b0;
	// a lost crystal parks low, as a dead oscillator would
	always #XH crystal_clock = xtal_run ? ~crystal_clock : 1'b0;
	always #VH vco_clock = ~vco_clock;
	// analog status settles late, so the block must synchronise it
	assign #50 loop_locked_in = lock_req;
	assign #50 loop_tracking_in = trk_req;
endmodule : pll_partner

// ---- testbench/pll_control_test.sv ----
// self-checking bench of the loop control block with a register model
`timescale 1ns/100ps
module pll_control_test
	import pll_pkg::*;
;
	// ------------------------------------------------------------
	// constants, signals and model state
	// ------------------------------------------------------------
	localparam int XH  = 170; // crystal half period, ns
	localparam int VH  = 130; // vco half period, ns
	localparam int WIN = 340; // rate window, cycles
	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, seed;
	logic        pready, pslverr, osc_en, xtal_run, lock_req, trk_req;
	logic        crystal_clock, vco_clock, locked, tracking;
	logic        xclk_o, base_o, irq, loop_en, auto_o, trk_o;
	logic [3:0]  mul_o, vrs_o, test_o;
	int          n_errors, comparisons, cycles, n;
	bit          m_ie, m_flag, m_on, m_bcs, m_auto, m_acq, m_xld;
	logic [3:0]  m_mul, m_vrs;
	// last entry is an unmapped word
	logic [7:0]  idx [4] = '{CTRL_INDEX, BWC_INDEX, PROG_INDEX, 8'h1f};

	pll_control dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.crystal_clock(crystal_clock), .vco_clock(vco_clock),
		.loop_locked_in(locked), .loop_tracking_in(tracking),
		.oscillator_enable_in(osc_en), .crystal_clock_out(xclk_o),
		.base_clock_out(base_o), .loop_irq_request(irq),
		.loop_enable_out(loop_en), .auto_bandwidth_out(auto_o),
		.manual_tracking_out(trk_o), .feedback_multiplier_out(mul_o),
		.vco_range_out(vrs_o), .factory_test_out(test_o));
	pll_partner #(.XH(XH), .VH(VH)) far_u (.xtal_run(xtal_run),
		.lock_req(lock_req), .trk_req(trk_req),
		.crystal_clock(crystal_clock), .vco_clock(vco_clock),
		.loop_locked_in(locked), .loop_tracking_in(tracking));

	// ------------------------------------------------------------
	// clock and hang guard
	// ------------------------------------------------------------
	always #10 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			results();
		end
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic results();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : xs

	// one apb transfer; holds everything until pready is seen high
	task automatic apb(input int k, input logic wr, input logic [7:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {2'b00, idx[k], 2'b00};
		pwdata  <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic logic [7:0] expv(input int k);
		case (k)
			0: return {m_ie, m_flag, m_on, m_bcs, CTRL_LOW_ONES};
			1: return {m_auto, m_auto & lock_req, m_auto ? trk_req : m_acq,
				m_bcs & m_xld & ~xtal_run, 4'h0};
			2: return {m_mul, m_vrs};
			default: return 8'h00;
		endcase
	endfunction : expv

	// outputs land on the access edge itself; looking two negedges on leaves a cycle spare
	task automatic outs();
		repeat (2) @(negedge pclk);
		chk("loop_en", 32'(loop_en), 32'(m_on & (m_vrs != 0) & osc_en));
		chk("irq", 32'(irq), 32'(m_ie & m_flag & osc_en));
		chk("auto", 32'(auto_o), 32'(m_auto));
		chk("trk", 32'(trk_o), 32'(m_acq));
		chk("mul", 32'(mul_o), 32'((m_mul == 0) ? 4'h1 : m_mul));
		chk("vrs", 32'(vrs_o), 32'(m_vrs));
		chk("test", 32'(test_o), 32'h0);
	endtask : outs

	task automatic rd(input int k);
		logic [31:0] q;
		logic        e;
		apb(k, 1'b0, 8'h00, q, e);
		chk($sformatf("reg%0d", k), q, {24'h0, expv(k)});
		chk("slverr", 32'(e), 32'(k == 3));
		if (k == 0) m_flag = 0;
		outs();
	endtask : rd

	// model update uses the values from before the write, except the new mode that clears enable and flag
	task automatic wr(input int k, input logic [7:0] d);
		logic [31:0] q;
		logic        e;
		bit          nb;
		apb(k, 1'b1, d, q, e);
		if (k == 0) begin
			nb = d[4] & m_on & (d[5] | m_bcs) & (m_vrs != 4'h0);
			m_on = d[5] | m_bcs;
			m_bcs = nb;
			m_ie = d[7] & m_auto;
		end else if (k == 1) begin
			if (!m_auto) m_acq = d[5];
			m_auto = d[7];
			m_xld = d[4] | m_xld;
			if (!m_auto) {m_ie, m_flag} = 2'b00;
		end else if (!m_on) begin
			{m_mul, m_vrs} = d;
		end
		outs();
	endtask : wr

	task automatic tog();
		@(posedge pclk);
		lock_req <= ~lock_req;
		repeat (12) @(posedge pclk);
		if (m_auto) m_flag = 1;
		outs();
	endtask : tog

	// base output toggles per selected rising edge, so per source period
	task automatic rate(input int half, input int win);
		logic last;
		int   e;
		@(negedge pclk);
		last = base_o;
		n = 0;
		e = win * 20 / (2 * half);
		repeat (win) begin
			@(negedge pclk);
			if (base_o !== last) n++;
			last = base_o;
		end
		chk("rate", 32'(n >= e - 1 && n <= e + 1), 32'h1);
	endtask : rate

	task automatic hold_xtal(input logic run);
		@(posedge pclk);
		xtal_run <= run;
		repeat (10) @(posedge pclk);
	endtask : hold_xtal

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{lock_req, trk_req, osc_en, xtal_run} = 4'h3;
		seed = 32'd92;
		{m_ie, m_flag, m_bcs, m_auto, m_acq, m_xld} = 6'h0;
		{m_on, m_mul, m_vrs} = {ON_RESET, MUL_RESET, VRS_RESET};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 4; k++) rd(k);
		// manual mode: enable, flag and lock held off
		wr(0, 8'he0);
		tog();
		tog();
		rd(0);
		wr(1, 8'h20);
		rd(1);
		// program register, open only while the loop is off
		wr(0, 8'h00);
		wr(2, 8'h05);
		repeat (6) wr(2, xs());
		wr(2, 8'h40);
		wr(0, 8'h30);
		rd(0);
		repeat (4) wr(2, xs());
		rd(2);
		wr(0, 8'h00);
		wr(2, 8'h47);
		// source select protection, freeze and vco rate
		wr(0, 8'h30);
		rd(0);
		wr(0, 8'h30);
		// short window: the switch ends after two to three crystal periods
		rate(1000000, 25);
		chk("freeze", 32'(n), 32'h0);
		repeat (80) @(posedge pclk);
		rate(VH, WIN);
		wr(0, 8'h10);
		rd(0);
		// crystal loss check while the vco drives the base clock
		hold_xtal(1'b0);
		wr(1, 8'h30);
		repeat (4 * m_mul) @(posedge pclk);
		rd(1);
		hold_xtal(1'b1);
		repeat (30) @(posedge pclk);
		m_xld = 0;
		rd(1);
		// automatic mode: status bits, lock flag and request
		wr(1, 8'ha0);
		rd(1);
		@(posedge pclk);
		trk_req <= 1'b1;
		repeat (10) @(posedge pclk);
		wr(1, 8'h80);
		rd(1);
		wr(0, 8'hb0);
		tog();
		rd(1);
		rd(0);
		wr(0, 8'h30);
		tog();
		rd(0);
		rd(0);
		wr(0, 8'hb0);
		tog();
		// stop: outputs low, select falls back to the crystal
		@(posedge pclk);
		osc_en <= 1'b0;
		m_bcs = 0;
		repeat (3) @(posedge pclk);
		n = 0;
		repeat (30) begin
			@(negedge pclk);
			n += int'(xclk_o | base_o | irq);
		end
		chk("stop", 32'(n), 32'h0);
		outs();
		@(posedge pclk);
		osc_en <= 1'b1;
		rd(0);
		// power off and select in one write: select must stay clear
		wr(0, 8'h10);
		repeat (100) @(posedge pclk);
		rate(XH, WIN);
		hold_xtal(1'b0);
		wr(1, 8'hb0);
		rd(1);
		hold_xtal(1'b1);
		m_xld = 0;
		wr(1, 8'h20);
		rd(1);
		rd(0);
		results();
	end
endmodule : pll_control_test
